/* File: core/swu_pkg.sv */
// Package for the serial write unit: register map, field positions and widths.
// Assumes a 32-bit APB bus with byte addresses and one register per aligned word.
package swu_pkg;
   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] SWU_OFF_NIBBLE   = 8'h00;  // serial_nibble_buffer, write loads.
   localparam logic [7:0] SWU_OFF_CTRL     = 8'h04;  // serial_control_high and rate select.
   localparam logic [7:0] SWU_OFF_STATUS   = 8'h08;  // Live state, read only.
   localparam logic [7:0] SWU_OFF_INT_STAT = 8'h0c;  // Sticky events, read only.
   localparam logic [7:0] SWU_OFF_INT_CLR  = 8'h10;  // Write one to clear, write only.
   localparam logic [7:0] SWU_OFF_INT_EN   = 8'h14;  // Interrupt enables.

   // ---------------------------------------------------------------
   // Field positions and widths
   // ---------------------------------------------------------------
   localparam int SWU_NIB_W      = 4;
   localparam int SWU_CTRL_GO    = 0;   // transmit_go_flag
   localparam int SWU_CTRL_RATE  = 1;   // serial_rate_select_register, two bits
   localparam int SWU_RATE_W     = 2;
   localparam int SWU_ST_TEST    = 0;   // test_flag_bit
   localparam int SWU_ST_EMPTY   = 1;   // buffer_empty_interrupt
   localparam int SWU_ST_BUSY    = 2;   // Shift register active.
   localparam int SWU_ST_FULL    = 3;   // Holding register loaded.
   localparam int SWU_EV_EMPTY   = 0;   // Nibble moved to the shift register.
   localparam int SWU_EV_DONE    = 1;   // Transmission ended by itself.
   localparam int SWU_EV_W       = 2;
   localparam int SWU_BIT_W      = 2;
   localparam logic [SWU_BIT_W-1:0] SWU_LAST_BIT = 2'h3;  // Most significant bit index.
   localparam logic [31:0] SWU_ZERO32 = 32'h0000_0000;
endpackage

/* File: core/swu_shift_if.sv */
// Interface between the serial write unit control and its nibble shifter.
// Assumes both ends run on the same pclk.
`timescale 1ns/10ps
interface swu_shift_if;
   logic       load;       // Take load_data into the shift register.
   logic [3:0] load_data;
   logic       abort;      // Drop the transfer at once.
   logic       tick;       // One half period of the serial clock.
   logic       busy;
   logic       fin;        // Falling clock edge of the last bit, one cycle.
   logic       sdata;
   logic       sclk;

   modport ctl (output load, output load_data, output abort, output tick,
                input busy, input fin, input sdata, input sclk);
   modport shf (input load, input load_data, input abort, input tick,
                output busy, output fin, output sdata, output sclk);
endinterface

/* File: core/swu_shifter.sv */
// Nibble shifter: sends four bits, least significant first, with its own clock.
// Assumes tick pulses once per serial half period from the control module.
`timescale 1ns/10ps
module swu_shifter
   import swu_pkg::*;
(
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Control side
   swu_shift_if.shf  sif
);
   typedef struct packed {
      logic                 busy;
      logic                 sclk;
      logic [SWU_BIT_W-1:0] idx;
      logic [SWU_NIB_W-1:0] sh;
   } swu_shf_state_t;

   swu_shf_state_t s_r;
   swu_shf_state_t s_nxt;

   // --------------------------------------------------------------
   // Bit sequencing
   // --------------------------------------------------------------
   // The last falling edge is flagged so a waiting nibble follows without a gap.
   assign sif.fin   = s_r.busy & s_r.sclk & sif.tick & (s_r.idx == SWU_LAST_BIT);
   assign sif.busy  = s_r.busy;
   assign sif.sdata = s_r.sh[0];
   assign sif.sclk  = s_r.sclk;

   // Next state: load wins over shifting, abort wins over both.
   always_comb begin
      s_nxt = s_r;
      if (sif.abort) begin
         s_nxt = '0;
      end else if (sif.load) begin
         s_nxt.busy = 1'b1;
         s_nxt.sclk = 1'b0;
         s_nxt.idx  = '0;
         s_nxt.sh   = sif.load_data;
      end else if (s_r.busy && sif.tick) begin
         if (!s_r.sclk) begin
            s_nxt.sclk = 1'b1;
         end else begin
            s_nxt.sclk = 1'b0;
            if (s_r.idx == SWU_LAST_BIT) begin
               s_nxt.busy = 1'b0;
            end else begin
               s_nxt.idx = s_r.idx + 1'b1;
               s_nxt.sh  = {1'b0, s_r.sh[SWU_NIB_W-1:1]};
            end
         end
      end
   end

   // State register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule // swu_shifter

/* File: core/swu_top.sv */
// Serial write unit in interactive mode: APB registers, nibble handover, interrupts.
// Assumes ser_clk_in is an asynchronous prescaler clock far slower than pclk.
//
// Notes on behaviour
// - Moving the final nibble into the shift register raises buffer-empty again.
// - Empty interrupt repeats while last nibble shifts; start bit then self-clears.
// - Software clearing the start bit aborts the shift register at once.
// - Dummy nibble write after transmission clears test flag and empty interrupt.
// - A nibble write clears buffer-empty interrupt and test flag, unless a handover sets them in the same cycle.
// - Nibble handover with start set raises empty interrupt and test flag.
`timescale 1ns/10ps
module swu_top
   import swu_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic             pslverr,
   output logic [31:0]      prdata,
   // Serial link
   input  wire logic        ser_clk_in,
   output logic             ser_data,
   output logic             ser_clk_out,
   // Interrupts
   output logic             buffer_empty_interrupt,
   output logic             irq
);
   typedef struct packed {
      logic                  sync1;
      logic                  sync2;
      logic                  sync3;
      logic [7:0]            div;
      logic                  tick;
      logic [SWU_NIB_W-1:0]  hold;
      logic                  full;
      logic                  go;
      logic [SWU_RATE_W-1:0] rate;
      logic                  test_flag;
      logic                  empty_irq;
      logic [SWU_EV_W-1:0]   ev;
      logic [SWU_EV_W-1:0]   ev_en;
      logic                  irq;
      logic                  rdy;
      logic                  err;
      logic [31:0]           rdata;
      logic                  sdata;
      logic                  sclk;
   } swu_top_state_t;

   swu_top_state_t s_r;
   swu_top_state_t s_nxt;
   swu_shift_if    sif ();

   // Address decode used for both the read and write paths.
   // Every word that is not listed here answers with pslverr and reads zero.
   function automatic logic swu_mapped(input logic [7:0] a);
      swu_mapped = (a == SWU_OFF_NIBBLE) || (a == SWU_OFF_CTRL) ||
                   (a == SWU_OFF_STATUS) || (a == SWU_OFF_INT_STAT) ||
                   (a == SWU_OFF_INT_CLR) || (a == SWU_OFF_INT_EN);
   endfunction

   logic       wr_acc;
   logic       load_now;
   logic       go_fall;
   logic [7:0] div_top;

   // --------------------------------------------------------------
   // Shifter
   // --------------------------------------------------------------
   swu_shifter u_shift (
      .pclk    (pclk),
      .presetn (presetn),
      .sif     (sif)
   );

   assign wr_acc        = psel & penable & s_r.rdy & pwrite;
   assign div_top       = (8'h01 << s_r.rate) - 8'h01;
   assign sif.tick      = s_r.tick;
   assign sif.load      = load_now;
   assign sif.load_data = s_r.hold;
   assign sif.abort     = go_fall;

   // Handover happens when idle or right at the last falling edge, so a nibble
   // written in time follows seamlessly; a late one waits for a new start.
   always_comb begin
      go_fall  = 1'b0;
      if (wr_acc && paddr == SWU_OFF_CTRL && !pwdata[SWU_CTRL_GO]) begin
         go_fall = s_r.go;
      end
      // An abort in the same cycle keeps the waiting nibble instead of losing it.
      load_now = s_r.go & s_r.full & (~sif.busy | sif.fin) & ~go_fall;
   end

   // --------------------------------------------------------------
   // Next state
   // --------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      // Two flops before the edge detector; sync1 feeds only sync2.
      // The third flop only remembers the last settled level for the edge test.
      // The prescaler clock must stay well below half of pclk, otherwise
      // edges are lost in the synchroniser and the serial rate drifts.
      // All three reset low, so a pin that idles low gives no false edge.
      s_nxt.sync1 = ser_clk_in;
      s_nxt.sync2 = s_r.sync1;
      s_nxt.sync3 = s_r.sync2;
      s_nxt.tick  = 1'b0;
      // Each rising prescaler edge counts; the rate picks a division of 1, 2, 4 or 8.
      if (s_r.sync2 && !s_r.sync3) begin
         if (s_r.div >= div_top) begin
            s_nxt.div  = '0;
            s_nxt.tick = 1'b1;
         end else begin
            s_nxt.div = s_r.div + 8'h01;
         end
      end

      // Repeated empty interrupts while the final nibble is still leaving.
      // A handler that returns before the start bit drops is entered again,
      // so it should poll the start bit before it leaves.
      if (s_r.go && sif.busy && !s_r.full && s_r.tick) begin
         s_nxt.empty_irq = 1'b1;
      end
      // End of the last nibble with nothing waiting: stop by itself.
      if (sif.fin && !s_r.full) begin
         s_nxt.go = 1'b0;
      end

      // APB write; takes effect only at the completing edge.
      if (wr_acc) begin
         unique case (paddr)
            SWU_OFF_NIBBLE: begin
               s_nxt.hold      = pwdata[SWU_NIB_W-1:0];
               s_nxt.full      = 1'b1;
               s_nxt.empty_irq = 1'b0;
               s_nxt.test_flag = 1'b0;
            end
            SWU_OFF_CTRL: begin
               s_nxt.go   = pwdata[SWU_CTRL_GO];
               s_nxt.rate = pwdata[SWU_CTRL_RATE +: SWU_RATE_W];
            end
            SWU_OFF_INT_CLR: s_nxt.ev    = s_r.ev & ~pwdata[SWU_EV_W-1:0];
            SWU_OFF_INT_EN:  s_nxt.ev_en = pwdata[SWU_EV_W-1:0];
            default: ;
         endcase
      end

      // Handover to the shifter; placed after the write so the set wins.
      if (load_now) begin
         s_nxt.full      = wr_acc && paddr == SWU_OFF_NIBBLE;
         s_nxt.empty_irq = 1'b1;
         s_nxt.test_flag = 1'b1;
         s_nxt.ev[SWU_EV_EMPTY] = 1'b1;
      end
      // The done event is set after the write, so a clear in the same cycle loses.
      if (sif.fin && !s_r.full) begin
         s_nxt.ev[SWU_EV_DONE] = 1'b1;
      end

      // The level follows the next state, so a clear drops it at the same edge.
      // Only the sticky events are maskable; the empty line is not.
      s_nxt.irq = |(s_nxt.ev & s_nxt.ev_en);
      s_nxt.sdata = sif.sdata;
      s_nxt.sclk  = sif.sclk;

      // APB answer: ready for exactly the first access cycle.
      // There are never wait states, so read data is latched in the setup cycle;
      // the registered answer costs nothing because the access phase is needed anyway.
      s_nxt.rdy   = psel & ~penable & ~s_r.rdy;
      s_nxt.err   = psel & ~penable & ~swu_mapped(paddr);
      s_nxt.rdata = SWU_ZERO32;
      if (psel && !penable && !pwrite) begin
         unique case (paddr)
            SWU_OFF_NIBBLE: s_nxt.rdata[SWU_NIB_W-1:0] = s_r.hold;
            SWU_OFF_CTRL: begin
               s_nxt.rdata[SWU_CTRL_GO] = s_r.go;
               s_nxt.rdata[SWU_CTRL_RATE +: SWU_RATE_W] = s_r.rate;
            end
            SWU_OFF_STATUS: begin
               s_nxt.rdata[SWU_ST_TEST]  = s_r.test_flag;
               s_nxt.rdata[SWU_ST_EMPTY] = s_r.empty_irq;
               s_nxt.rdata[SWU_ST_BUSY]  = sif.busy;
               s_nxt.rdata[SWU_ST_FULL]  = s_r.full;
            end
            SWU_OFF_INT_STAT: s_nxt.rdata[SWU_EV_W-1:0] = s_r.ev;
            SWU_OFF_INT_EN:   s_nxt.rdata[SWU_EV_W-1:0] = s_r.ev_en;
            default: ;
         endcase
      end
   end

   // State register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // --------------------------------------------------------------
   // Outputs, all from flops
   // --------------------------------------------------------------
   // The link pins are a registered copy of the shifter, one cycle behind the
   // empty flag; clock and data move together, so their relation is kept.
   assign pready                 = s_r.rdy;
   assign pslverr                = s_r.err;
   assign prdata                 = s_r.rdata;
   assign ser_data               = s_r.sdata;
   assign ser_clk_out            = s_r.sclk;
   assign buffer_empty_interrupt = s_r.empty_irq;
   assign irq                    = s_r.irq;
endmodule // swu_top

/* File: bench/swu_props.sv */
// Checker for the serial write unit: link, interrupt and write timing.
// Assumes a bind to swu_top; it sees only that module's ports.
`timescale 1ns/10ps
module swu_props
   import swu_pkg::*;
(
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // Bus
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   // Link and interrupt
   input wire logic        ser_data,
   input wire logic        ser_clk_out,
   input wire logic        buffer_empty_interrupt
);
   // -----------------------------------------------------------
   // Properties
   // -----------------------------------------------------------
   logic wr_nib;
   logic wr_stop;
   // Completed writes; they take effect on the edge that ends the access.
   assign wr_nib  = psel && penable && pready && pwrite && paddr == SWU_OFF_NIBBLE;
   assign wr_stop = psel && penable && pready && pwrite && paddr == SWU_OFF_CTRL && !pwdata[0];
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_nib_clears_empty: assert property (wr_nib |=> !buffer_empty_interrupt)
      else $error("empty flag survived a nibble write");
   a_empty_held: assert property ($fell(buffer_empty_interrupt) |-> $past(wr_nib))
      else $error("empty flag dropped without a nibble write");
   a_empty_at_load: assert property ($rose(buffer_empty_interrupt) |=> !ser_clk_out)
      else $error("empty flag rose while the serial clock was high");
   a_load_then_clock: assert property ($rose(buffer_empty_interrupt) |-> ##[1:80] ser_clk_out)
      else $error("no serial clock after a handover");
   a_stop_quiet: assert property (wr_stop |=> ##[0:3] (!ser_clk_out && !ser_data) [*4])
      else $error("link still active after the start bit was cleared");
   a_data_steady: assert property (ser_clk_out && $past(ser_clk_out) |-> $stable(ser_data))
      else $error("serial data moved while the clock was high");
   a_clock_high_len: assert property ($rose(ser_clk_out) |-> ##[1:80] !ser_clk_out)
      else $error("serial clock high too long");
endmodule // swu_props
bind swu_top swu_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .ser_data(ser_data),
   .ser_clk_out(ser_clk_out), .buffer_empty_interrupt(buffer_empty_interrupt));

/* File: bench/swu_rx_model.sv */
// Far-side serial receiver: shifts in bits and measures the clock period.
// Assumes data is taken on the rising serial clock, least significant first.
`timescale 1ns/10ps
module swu_rx_model (
   // Clock and reset
   input wire logic   pclk,
   input wire logic   presetn,
   // Link
   input wire logic   ser_data,
   input wire logic   ser_clk_out,
   // Observations
   output logic [7:0]  rx_shift,
   output logic [15:0] rx_gap
);
   logic        clk_d;
   logic [15:0] cnt;
   // Data is only promised while the clock is high, so take it at the rise.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_d <= 1'b0;
         rx_shift <= 8'h00;
         rx_gap <= 16'h0000;
         cnt <= 16'h0000;
      end else begin
         clk_d <= ser_clk_out;
         cnt <= cnt + 16'h0001;
         if (ser_clk_out && !clk_d) begin
            rx_shift <= {ser_data, rx_shift[7:1]};
            rx_gap <= cnt;
            cnt <= 16'h0001;
         end
      end
   end
endmodule // swu_rx_model

/* File: bench/swu_top_tb.sv */
// Bench for the serial write unit: APB calls with expected values.
// Assumes the checker bind and the receiver model are compiled first.
`timescale 1ns/10ps
module swu_top_tb
   import swu_pkg::*;
;
   // -----------------------------------------------------------
   // Signals
   // -----------------------------------------------------------
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic        ser_clk_in = 1'b0;
   logic        pready, pslverr, ser_data, ser_clk_out, buffer_empty_interrupt, irq;
   logic [31:0] prdata;
   logic [31:0] q;
   logic        e;
   logic [7:0]  rx_shift;
   logic [15:0] rx_gap;
   int          n_errors = 0;
   int          checks = 0;
   int          k;
   logic [1:0]  lc = 2'h0;
   // Bus clock, and an 800 ns link clock stepped on its rising edges.
   always #50 pclk = ~pclk;
   always @(posedge pclk) begin
      lc <= lc + 2'h1;
      if (lc == 2'h3) begin
         ser_clk_in <= ~ser_clk_in;
      end
   end
   swu_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
      .prdata(prdata), .ser_clk_in(ser_clk_in), .ser_data(ser_data), .irq(irq),
      .ser_clk_out(ser_clk_out), .buffer_empty_interrupt(buffer_empty_interrupt));
   swu_rx_model rx (.pclk(pclk), .presetn(presetn), .ser_data(ser_data),
      .ser_clk_out(ser_clk_out), .rx_shift(rx_shift), .rx_gap(rx_gap));
   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One APB transfer; the idle cycle after it keeps drivers single per step.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         check("bus answer", 32'h1, 32'h0);
         report_and_stop();
      end
      @(posedge pclk);
   endtask
   // Waits for the empty flag (0) or the serial clock (1), bounded.
   task automatic wait_for(input logic which);
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while ((which ? ser_clk_out : buffer_empty_interrupt) !== 1'b1 && n < 3000);
      if (n >= 3000) begin
         check("wait", 32'h1, 32'h0);
         report_and_stop();
      end
   endtask
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, SWU_OFF_STATUS, SWU_ZERO32);
      check("status reset", 32'h0, q);
      apb(1'b0, 8'h40, SWU_ZERO32);
      check("unmapped error", 32'h1, {31'h0, e});
      apb(1'b1, SWU_OFF_INT_EN, 32'h3);
      for (int r = 0; r < 4; r++) begin
         apb(1'b1, SWU_OFF_NIBBLE, 32'h5);
         apb(1'b1, SWU_OFF_CTRL, {29'h0, 2'(r), 1'b1});
         wait_for(1'b0);
         apb(1'b0, SWU_OFF_STATUS, SWU_ZERO32);
         check("flags at handover", 32'h3, q & 32'h3);
         check("irq at handover", 32'h1, {31'h0, irq});
         apb(1'b1, SWU_OFF_NIBBLE, 32'ha);
         apb(1'b0, SWU_OFF_STATUS, SWU_ZERO32);
         check("flags after write", 32'h0, q & 32'h3);
         wait_for(1'b0);
         k = 0;
         do begin
            apb(1'b0, SWU_OFF_CTRL, SWU_ZERO32);
            k++;
         end while (q[0] !== 1'b0 && k < 500);
         check("start cleared", 32'h0, {31'h0, q[0]});
         if (q[0] !== 1'b0) begin
            report_and_stop();
         end
         check("empty kept", 32'h1, {31'h0, buffer_empty_interrupt});
         check("data sent", 32'ha5, {24'h0, rx_shift});
         check("clock period", 32'd16 << r, {16'h0, rx_gap});
         apb(1'b0, SWU_OFF_INT_STAT, SWU_ZERO32);
         check("events", 32'h3, q);
         apb(1'b1, SWU_OFF_INT_CLR, 32'h3);
         check("irq cleared", 32'h0, {31'h0, irq});
         apb(1'b1, SWU_OFF_NIBBLE, SWU_ZERO32);
         apb(1'b0, SWU_OFF_STATUS, SWU_ZERO32);
         check("flags after dummy", 32'h0, q & 32'h3);
      end
      // Stop after the first bit; further bits would change the receiver.
      apb(1'b1, SWU_OFF_NIBBLE, 32'hf);
      apb(1'b1, SWU_OFF_CTRL, 32'h3);
      wait_for(1'b1);
      apb(1'b1, SWU_OFF_CTRL, 32'h2);
      repeat (40) @(posedge pclk);
      check("bits before stop", 32'hd2, {24'h0, rx_shift});
      apb(1'b0, SWU_OFF_STATUS, SWU_ZERO32);
      check("busy after stop", 32'h0, q & 32'h4);
      report_and_stop();
   end
endmodule // swu_top_tb
